// >>> inc/dws_pkg.sv
// Contract
// RULE_01: Window and independent watchdogs keep separate counters, tick sources and resets.
// RULE_02: Option strap or software command activates; only a device reset deactivates.
// RULE_03: Software reloads the window counter before timeout and inside the window.
// RULE_04: Window counter expiring without refresh requests reset; 75 us to 64 ms. The code's shortest timeout is one WW_PRESCALE step, 1 ms at 16 MHz.
// RULE_05: Window reload while counter above window value requests reset.
// RULE_06: Independent watchdog counts low-speed oscillator edges, surviving CPU clock loss.
// RULE_07: Independent timeout spans 60 us to 1 s by prescaler and reload. The code gives 31.25 us to 1.024 s at 128 kHz.
// RULE_08: Both reset requests merge into one system reset request output.
//
package dws_pkg;

   // ****************************************************************
   // Window watchdog
   // ****************************************************************
   localparam int WW_CNT_W = 7;
   localparam int WW_TIMEOUT_BIT = 6;
   localparam logic [WW_CNT_W-1:0] WW_CNT_RST = 7'h7f;
   localparam logic [WW_CNT_W-1:0] WW_WIN_RST = 7'h7f;
   localparam logic [WW_CNT_W-1:0] WW_CNT_LAST = 7'h40;
   localparam int WW_CPU_HZ = 16000000;
   localparam int WW_TMIN_US = 75;
   localparam int WW_TMAX_US = 64000;
   localparam int WW_STEPS = 64;
   // CPU clock ticks per counter step, so 64 steps give the longest timeout.
   localparam int WW_PRESCALE = WW_TMAX_US * (WW_CPU_HZ / 1000000) / WW_STEPS;
   localparam int WW_DIV_W = 14;

   // ****************************************************************
   // Independent watchdog
   // ****************************************************************
   localparam int IW_OSC_HZ = 128000;
   localparam int IW_TMIN_US = 60;
   localparam int IW_TMAX_US = 1000000;
   localparam int IW_RLD_W = 8;
   localparam int IW_SEL_W = 3;
   localparam int IW_DIV_W = 10;
   localparam logic [IW_RLD_W-1:0] IW_RLD_RST = 8'hff;
   localparam logic [IW_SEL_W-1:0] IW_SEL_RST = 3'h0;
   localparam logic [IW_DIV_W-1:0] IW_PRE_BASE = 10'h004;
   localparam logic [IW_RLD_W-1:0] IW_CNT_ZERO = 8'h00;

endpackage

// >>> design/dws_divider.sv
`timescale 1ns/1ps
module dws_divider #(
   parameter int DIV_W = 10
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Input ticks, restart and ratio.
   input wire logic tick_in,
   input wire logic restart,
   input wire logic [DIV_W-1:0] ratio,
   // Output tick, one pulse per ratio input ticks.
   output logic tick_out
);
   import dws_pkg::*;

   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic last;

   // A ratio of zero behaves as one so the output never stops for good.
   assign last = (cnt_q >= ratio - DIV_W'(1)) || (ratio == '0);
   assign tick_out = tick_in && last && !restart;

   // Restart discards the partial period so a refresh gets a full step.
   always_comb begin
      cnt_d = cnt_q;
      if (restart) begin
         cnt_d = '0;
      end else if (tick_in) begin
         cnt_d = last ? '0 : cnt_q + DIV_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// >>> design/dws_top.sv
`timescale 1ns/1ps
module dws_top #(
   parameter int WW_DIV = dws_pkg::WW_PRESCALE
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Option straps, read once after reset release.
   input wire logic opt_window_en,
   input wire logic opt_indep_en,
   // CPU clock enable, one pulse per CPU clock cycle.
   input wire logic cpu_tick,
   // Low-speed oscillator pin, asynchronous.
   input wire logic low_speed_internal_osc,
   // Window watchdog software port.
   input wire logic ww_activate,
   input wire logic ww_count_wr,
   input wire logic [dws_pkg::WW_CNT_W-1:0] ww_count_in,
   input wire logic ww_window_wr,
   input wire logic [dws_pkg::WW_CNT_W-1:0] ww_window_in,
   // Independent watchdog software port.
   input wire logic iw_activate,
   input wire logic iw_refresh,
   input wire logic iw_cfg_wr,
   input wire logic [dws_pkg::IW_SEL_W-1:0] iw_sel_in,
   input wire logic [dws_pkg::IW_RLD_W-1:0] iw_reload_in,
   // Status.
   output logic ww_active,
   output logic [dws_pkg::WW_CNT_W-1:0] ww_count,
   output logic iw_active,
   output logic [dws_pkg::IW_RLD_W-1:0] iw_count,
   output logic ww_reset_flag,
   output logic iw_reset_flag,
   // Merged reset request.
   output logic sys_reset_req
);
   import dws_pkg::*;

   // ****************************************************************
   // Oscillator synchroniser and edge detect
   // ****************************************************************
   logic osc_meta_q;
   logic osc_sync_q;
   logic osc_prev_q;
   logic osc_rise;

   // The first stage feeds only the second one.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         osc_meta_q <= 1'b0;
         osc_sync_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_meta_q <= low_speed_internal_osc;
         osc_sync_q <= osc_meta_q;
         osc_prev_q <= osc_sync_q;
      end
   end

   // The independent time base comes from the oscillator alone.
   assign osc_rise = osc_sync_q && !osc_prev_q; // see RULE_06

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   logic boot_done_q;
   logic boot_done_d;
   logic strap_now;

   // Straps are sampled in the first clocked cycle after release, never in reset.
   assign strap_now = !boot_done_q;

   always_comb begin
      boot_done_d = 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         boot_done_q <= 1'b0;
      end else begin
         boot_done_q <= boot_done_d;
      end
   end

   // ****************************************************************
   // Window watchdog
   // ****************************************************************
   logic ww_act_q;
   logic ww_act_d;
   logic [WW_CNT_W-1:0] ww_cnt_q;
   logic [WW_CNT_W-1:0] ww_cnt_d;
   logic [WW_CNT_W-1:0] ww_win_q;
   logic [WW_CNT_W-1:0] ww_win_d;
   logic ww_rst_q;
   logic ww_rst_d;
   logic ww_step;
   logic ww_timeout;
   logic ww_early;
   logic ww_bad_load;

   // The window prescaler runs on the CPU clock, so it halts if that clock fails.
   dws_divider #(
      .DIV_W(WW_DIV_W)
   ) u_ww_div (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick_in(cpu_tick),
      .restart(ww_count_wr),
      .ratio(WW_DIV_W'(WW_DIV)),
      .tick_out(ww_step)
   );

   // Expiry is the step that would clear the timeout bit.
   assign ww_timeout = ww_act_q && ww_step && !ww_count_wr
      && (ww_cnt_q == WW_CNT_LAST); // see RULE_04
   // A reload while the count still sits above the window is too early.
   assign ww_early = ww_act_q && ww_count_wr && (ww_cnt_q > ww_win_q); // see RULE_05
   // Loading a value with the timeout bit clear expires at once.
   assign ww_bad_load = ww_act_q && ww_count_wr && !ww_count_in[WW_TIMEOUT_BIT];

   // Activation is sticky; nothing but reset clears it.
   always_comb begin
      ww_act_d = ww_act_q || ww_activate || (strap_now && opt_window_en); // see RULE_02
      ww_win_d = ww_window_wr ? ww_window_in : ww_win_q;
      ww_cnt_d = ww_cnt_q;
      if (ww_count_wr) begin
         ww_cnt_d = ww_count_in;
      end else if (ww_step) begin
         ww_cnt_d = ww_cnt_q - WW_CNT_W'(1);
      end
      ww_rst_d = ww_rst_q || ww_timeout || ww_early || ww_bad_load;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ww_act_q <= 1'b0;
         ww_cnt_q <= WW_CNT_RST;
         ww_win_q <= WW_WIN_RST;
         ww_rst_q <= 1'b0;
      end else begin
         ww_act_q <= ww_act_d;
         ww_cnt_q <= ww_cnt_d;
         ww_win_q <= ww_win_d;
         ww_rst_q <= ww_rst_d;
      end
   end

   // ****************************************************************
   // Independent watchdog
   // ****************************************************************
   logic iw_act_q;
   logic iw_act_d;
   logic [IW_RLD_W-1:0] iw_cnt_q;
   logic [IW_RLD_W-1:0] iw_cnt_d;
   logic [IW_RLD_W-1:0] iw_rld_q;
   logic [IW_RLD_W-1:0] iw_rld_d;
   logic [IW_SEL_W-1:0] iw_sel_q;
   logic [IW_SEL_W-1:0] iw_sel_d;
   logic iw_rst_q;
   logic iw_rst_d;
   logic iw_step;
   logic iw_start;
   logic iw_reload;
   logic [IW_DIV_W-1:0] iw_ratio;

   // Ratio is 4 shifted by the select, giving 4 up to 512 oscillator edges.
   assign iw_ratio = IW_PRE_BASE << iw_sel_q; // see RULE_07
   assign iw_start = !iw_act_q && iw_act_d;
   assign iw_reload = iw_start || (iw_act_q && iw_refresh);

   // Separate divider instance; it shares no state with the window side.
   dws_divider #(
      .DIV_W(IW_DIV_W)
   ) u_iw_div (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick_in(osc_rise),
      .restart(iw_reload),
      .ratio(iw_ratio),
      .tick_out(iw_step)
   ); // see RULE_01

   // Configuration is accepted any time; the reload value applies from the next reload, the select at once.
   always_comb begin
      iw_act_d = iw_act_q || iw_activate || (strap_now && opt_indep_en); // see RULE_02
      iw_rld_d = iw_cfg_wr ? iw_reload_in : iw_rld_q;
      iw_sel_d = iw_cfg_wr ? iw_sel_in : iw_sel_q;
      iw_cnt_d = iw_cnt_q;
      iw_rst_d = iw_rst_q;
      if (iw_reload) begin
         iw_cnt_d = iw_rld_q;
      end else if (iw_act_q && iw_step) begin
         if (iw_cnt_q == IW_CNT_ZERO) begin
            iw_rst_d = 1'b1; // see RULE_06
         end else begin
            iw_cnt_d = iw_cnt_q - IW_RLD_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         iw_act_q <= 1'b0;
         iw_cnt_q <= IW_RLD_RST;
         iw_rld_q <= IW_RLD_RST;
         iw_sel_q <= IW_SEL_RST;
         iw_rst_q <= 1'b0;
      end else begin
         iw_act_q <= iw_act_d;
         iw_cnt_q <= iw_cnt_d;
         iw_rld_q <= iw_rld_d;
         iw_sel_q <= iw_sel_d;
         iw_rst_q <= iw_rst_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic sys_req_q;
   logic sys_req_d;

   // The request holds until the reset controller resets this block.
   always_comb begin
      sys_req_d = sys_req_q || ww_rst_q || iw_rst_q; // see RULE_08
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sys_req_q <= 1'b0;
      end else begin
         sys_req_q <= sys_req_d;
      end
   end

   assign sys_reset_req = sys_req_q;
   assign ww_active = ww_act_q;
   assign ww_count = ww_cnt_q;
   assign iw_active = iw_act_q;
   assign iw_count = iw_cnt_q;
   assign ww_reset_flag = ww_rst_q;
   assign iw_reset_flag = iw_rst_q;

endmodule

// >>> tb/dws_top_properties.sv
`timescale 1ns/1ps
// ****************************************************************
// Watchdog port checker
// ****************************************************************
module dws_top_properties (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Controls.
   input wire logic opt_window_en,
   input wire logic ww_count_wr,
   input wire logic [dws_pkg::WW_CNT_W-1:0] ww_count_in,
   input wire logic ww_window_wr,
   input wire logic [dws_pkg::WW_CNT_W-1:0] ww_window_in,
   input wire logic iw_activate,
   // Status and request.
   input wire logic ww_active,
   input wire logic [dws_pkg::WW_CNT_W-1:0] ww_count,
   input wire logic iw_active,
   input wire logic ww_reset_flag,
   input wire logic iw_reset_flag,
   input wire logic sys_reset_req
);
   import dws_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Window value as software last wrote it, rebuilt from the write port alone.
   logic [WW_CNT_W-1:0] win_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         win_q <= WW_WIN_RST;
      end else if (ww_window_wr) begin
         win_q <= ww_window_in;
      end
   end

   // A refresh overrides a step in the same cycle, so the load value must appear.
   AST_WW_LOAD: assert property (ww_count_wr |=> ww_count == $past(ww_count_in))
      else $error("window counter missed a load");
   AST_WW_STRAP: assert property (!rst && $past(rst) && opt_window_en |=> ww_active)
      else $error("window strap not honoured");
   AST_IW_ACT: assert property (iw_activate |=> iw_active)
      else $error("independent activation lost");
   AST_ACT_HOLD: assert property (!$fell(ww_active) && !$fell(iw_active))
      else $error("a watchdog was switched off");
   AST_WW_TIMEOUT: assert property (
      ww_active && ww_count == WW_CNT_LAST ##1 ww_count == WW_CNT_LAST - WW_CNT_W'(1)
      |-> ww_reset_flag)
      else $error("window expiry without reset");
   AST_WW_LOW_LOAD: assert property (
      ww_active && ww_count_wr && !ww_count_in[WW_TIMEOUT_BIT] |=> ww_reset_flag)
      else $error("load below expiry without reset");
   // A refresh above the window must fire; one inside it must leave the flag alone.
   AST_WW_EARLY: assert property (
      ww_active && ww_count_wr && (ww_count > win_q) |=> ww_reset_flag)
      else $error("early refresh without reset");
   AST_WW_IN_WINDOW: assert property (
      ww_active && ww_count_wr && (ww_count <= win_q) && ww_count_in[WW_TIMEOUT_BIT]
      && !ww_reset_flag |=> !ww_reset_flag)
      else $error("refresh inside window caused reset");
   // An idle window watchdog wraps freely, so its flag may only rise while active.
   AST_WW_QUIET: assert property ($rose(ww_reset_flag) |-> $past(ww_active))
      else $error("inactive window watchdog fired");
   AST_REQ_MERGE: assert property ((ww_reset_flag || iw_reset_flag) |=> sys_reset_req)
      else $error("request did not follow a flag");
   AST_REQ_STICKY: assert property (
      !$fell(sys_reset_req) && !$fell(ww_reset_flag) && !$fell(iw_reset_flag))
      else $error("reset request dropped before reset");
   COV_WW: cover property ($rose(ww_reset_flag));
   COV_IW: cover property ($rose(iw_reset_flag));
   COV_OK: cover property (ww_active && ww_count_wr && ww_count_in[WW_TIMEOUT_BIT]);
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
// ****************************************************************
// Watchdog bench
// ****************************************************************
module testbench;
   import dws_pkg::*;
   logic ref_clk, rst, opt_window_en, opt_indep_en, cpu_tick, osc;
   logic ww_activate, ww_count_wr, ww_window_wr, iw_activate, iw_refresh, iw_cfg_wr;
   logic [WW_CNT_W-1:0] ww_count_in, ww_window_in, ww_count;
   logic [IW_SEL_W-1:0] iw_sel_in;
   logic [IW_RLD_W-1:0] iw_reload_in, iw_count;
   logic ww_active, iw_active, ww_reset_flag, iw_reset_flag, sys_reset_req;
   int mismatches, n_checks, n;

   dws_top #(.WW_DIV(4)) dut (.ref_clk(ref_clk), .rst(rst), .opt_window_en(opt_window_en),
      .opt_indep_en(opt_indep_en), .cpu_tick(cpu_tick), .low_speed_internal_osc(osc),
      .ww_activate(ww_activate), .ww_count_wr(ww_count_wr), .ww_count_in(ww_count_in),
      .ww_window_wr(ww_window_wr), .ww_window_in(ww_window_in), .iw_activate(iw_activate),
      .iw_refresh(iw_refresh), .iw_cfg_wr(iw_cfg_wr), .iw_sel_in(iw_sel_in),
      .iw_reload_in(iw_reload_in), .ww_active(ww_active), .ww_count(ww_count),
      .iw_active(iw_active), .iw_count(iw_count), .ww_reset_flag(ww_reset_flag),
      .iw_reset_flag(iw_reset_flag), .sys_reset_req(sys_reset_req));

   // The oscillator free-runs with no phase tie to the main clock.
   initial begin
      ref_clk = 0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      osc = 0;
      forever #3906 osc = ~osc;
   end

   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge ref_clk);
   endtask
   // One-cycle pulse; never call twice on one signal without a tick between.
   task automatic go(ref logic s);
      s = 1;
      tick(1);
      s = 0;
   endtask
   // Bounded wait; a flag that never comes ends the run as a failure.
   task automatic wait_flag(ref logic f, input int lim);
      n = 0;
      while (f !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      if (n >= lim) begin
         mismatches++;
         $display("wrong value at %0t: wait ran out", $time);
         close_out();
      end
   endtask
   // The CPU clock is held still through reset so counters start from known values.
   task automatic do_reset(input logic w, input logic i);
      {ww_activate, ww_count_wr, ww_window_wr, iw_activate, iw_refresh, iw_cfg_wr} = '0;
      {ww_count_in, ww_window_in, iw_sel_in, iw_reload_in} = '0;
      opt_window_en = w;
      opt_indep_en = i;
      cpu_tick = 0;
      rst = 1;
      tick(2);
      rst = 0;
      tick(1);
   endtask

   task automatic t_reset;
      do_reset(0, 0);
      chk(ww_count, 8'h7f);
      chk(iw_count, 8'hff);
      chk({ww_active, iw_active, ww_reset_flag, iw_reset_flag, sys_reset_req}, 8'h00);
      cpu_tick = 1;
      tick(300);
      chk(ww_reset_flag, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_strap;
      do_reset(1, 1);
      chk({ww_active, iw_active}, 8'h03);
      cpu_tick = 1;
      wait_flag(ww_reset_flag, 400);
      chk(ww_active, 8'h01);
      $display("test strap done");
   endtask
   task automatic t_ww_timeout;
      do_reset(0, 0);
      cpu_tick = 1;
      go(ww_activate);
      ww_count_in = 7'h7f;
      go(ww_count_wr);
      wait_flag(ww_reset_flag, 400);
      chk(n inside {[250:262]}, 8'h01);
      chk(ww_count, 8'h3f);
      chk(iw_reset_flag, 8'h00);
      tick(1);
      chk(sys_reset_req, 8'h01);
      $display("test window timeout done");
   endtask
   task automatic t_ww_window;
      do_reset(0, 0);
      ww_window_in = 7'h50;
      go(ww_window_wr);
      ww_count_in = 7'h7f;
      go(ww_count_wr);
      tick(2);
      chk(ww_reset_flag, 8'h00);
      go(ww_activate);
      go(ww_count_wr);
      tick(1);
      chk({ww_reset_flag, sys_reset_req}, 8'h03);
      do_reset(0, 0);
      go(ww_activate);
      ww_count_in = 7'h60;
      go(ww_count_wr);
      tick(1);
      chk(ww_reset_flag, 8'h00);
      ww_count_in = 7'h3f;
      go(ww_count_wr);
      tick(1);
      chk(ww_reset_flag, 8'h01);
      $display("test window refresh done");
   endtask
   // CPU clock stays stopped here: only the oscillator may drive this timeout.
   task automatic t_iw;
      do_reset(0, 0);
      iw_reload_in = 8'h01;
      go(iw_cfg_wr);
      go(iw_activate);
      chk(iw_active, 8'h01);
      chk(iw_count, 8'h01);
      wait_flag(iw_reset_flag, 2500);
      chk(n inside {[1300:1800]}, 8'h01);
      chk(ww_reset_flag, 8'h00);
      tick(1);
      chk(sys_reset_req, 8'h01);
      $display("test independent done");
   endtask

   // A refresh restarts the prescaler too, so the timeout counts whole steps from it.
   task automatic t_iw_refresh;
      do_reset(0, 0);
      iw_sel_in = 3'h1;
      iw_reload_in = 8'h01;
      go(iw_cfg_wr);
      go(iw_refresh);
      tick(1);
      chk(iw_count, 8'hff);
      go(iw_activate);
      tick(1000);
      chk(iw_count, 8'h01);
      chk(iw_reset_flag, 8'h00);
      go(iw_refresh);
      wait_flag(iw_reset_flag, 4000);
      chk(n inside {[2900:3200]}, 8'h01);
      $display("test independent refresh done");
   endtask

   initial begin
      t_reset();
      t_strap();
      t_ww_timeout();
      t_ww_window();
      t_iw();
      t_iw_refresh();
      close_out();
   end
endmodule

bind dws_top dws_top_properties u_props (.ref_clk(ref_clk), .rst(rst),
   .opt_window_en(opt_window_en), .ww_count_wr(ww_count_wr), .ww_count_in(ww_count_in),
   .ww_window_wr(ww_window_wr), .ww_window_in(ww_window_in),
   .iw_activate(iw_activate), .ww_active(ww_active), .ww_count(ww_count),
   .iw_active(iw_active), .ww_reset_flag(ww_reset_flag), .iw_reset_flag(iw_reset_flag),
   .sys_reset_req(sys_reset_req));
